// ---- include/cie_pkg.sv ----
// Purpose: shared constants for the instruction decode and execute block
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes: opcode patterns are compared on the upper instruction bits
package cie_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int INSN_W = 16;
  // opcode patterns on bits 15:8 (with masks)
  localparam logic [7:0] OP_LIT_LOAD = 8'h0E;
  localparam logic [7:0] OP_ACC_STORE = 8'h6E;
  localparam logic [7:0] OP_ACC_STORE_MASK = 8'hFE;
  localparam logic [7:0] OP_IDX_ADD = 8'h24;
  localparam logic [7:0] OP_IDX_ADD_MASK = 8'hFD;
  localparam logic [7:0] OP_IDX_BSET = 8'h80;
  localparam logic [7:0] OP_IDX_BSET_MASK = 8'hF1;
  localparam logic [7:0] OP_IDX_ONES = 8'h68;
  // field positions
  localparam int ACCESS_BIT = 8;
  localparam int DEST_BIT = 9;
  localparam int BIT_IDX_LSB = 9;
  localparam int OFS7_W = 7;
  // limits and values
  localparam logic [7:0] IDX_OFFSET_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] SHORT_ADDR_MAX = 8'hFE;
  localparam logic [11:0] SRC_ADDR_MAX = 12'hFFF;
  localparam logic [11:0] DST_ADDR_MAX = 12'hFEF;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] WORKING_ACCUMULATOR_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam int FLAG_W = 5;
  // table pointer update modes
  typedef enum logic [1:0] {
    CIE_TBL_NONE = 2'h0,
    CIE_TBL_POST_INC = 2'h1,
    CIE_TBL_POST_DEC = 2'h2,
    CIE_TBL_PRE_INC = 2'h3
  } cie_tbl_mode_t;
  typedef enum logic [1:0] {
    CIE_Q1_DECODE,
    CIE_Q2_READ,
    CIE_Q3_PROCESS,
    CIE_Q4_WRITE
  } cie_phase_t;
endpackage : cie_pkg

// ---- hdl/cie_core.sv ----
// Purpose: four-phase decode and execute of a subset of the core instructions
// Assumes: one instruction word presented per cycle of four phases; data RAM
//   answers a read combinationally in the same phase
// Notes: field decoders for the remaining formats are exported as outputs
// Contract
// - literal load 0000 1110 kkkkkkkk copies literal into accumulator, flags kept
// - accumulator store 0110 111a stores accumulator; a=0, extended, f<=95 uses index
// - access bit 0 uses access RAM; access bit 1 uses bank select register
// - indexed add 0010 01d0: accumulator plus indexed byte to accumulator or memory
// - five ALU flags kept; indexed add updates all, the others none
// - indexed all-ones 0110 1000 writes FFh at pointer plus offset, no flags
// - three-bit bit index selects bit 0 to 7 of a byte
// - short file field is an 8-bit address or 2-bit pointer designator
// - move source spans 000h-FFFh; destination limited to 000h-FEFh
// - table pointer mode: none, post-increment, post-decrement, pre-increment
// - fast select 0 leaves shadows; 1 saves on call, restores on return
// - indirect moves add 7-bit source and destination offsets to pointers
// - relative branches add two's complement offset; calls use direct address
// - literal field width is 8, 12 or 20 bits by instruction
`timescale 1ns/1ps
module cie_core
#(
  parameter int PC_W = 21
)
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [cie_pkg::INSN_W-1:0] INSN_I,
  input wire logic EXT_SET_EN_I,
  input wire logic [3:0] BANK_SELECT_REG_I,
  input wire logic [cie_pkg::ADDR_W-1:0] SECOND_INDEX_POINTER_I,
  input wire logic [cie_pkg::DATA_W-1:0] RAM_RDATA_I,
  input wire logic [PC_W-1:0] PC_I,
  input wire logic [cie_pkg::ADDR_W-1:0] MOVE_SRC_I,
  input wire logic [cie_pkg::ADDR_W-1:0] MOVE_DST_I,
  input wire logic [cie_pkg::ADDR_W-1:0] SRC_POINTER_I,
  input wire logic [cie_pkg::ADDR_W-1:0] DST_POINTER_I,
  input wire logic [20:0] TABLE_POINTER_I,
  input wire logic [1:0] POINTER_UPDATE_MODE_I,
  input wire logic FAST_SELECT_I,
  input wire logic IS_CALL_I,
  input wire logic IS_RETURN_I,
  input wire logic [10:0] BRANCH_OFFSET_I,
  input wire logic [1:0] LIT_WIDTH_SEL_I,
  output logic INSN_TAKE_O,
  output logic [1:0] PHASE_O,
  output logic [cie_pkg::ADDR_W-1:0] RAM_ADDR_O,
  output logic RAM_RD_O,
  output logic RAM_WR_O,
  output logic [cie_pkg::DATA_W-1:0] RAM_WDATA_O,
  output logic [cie_pkg::DATA_W-1:0] WORKING_ACCUMULATOR_O,
  output logic [4:0] STATUS_FLAGS_O,
  output logic ILLEGAL_O,
  output logic [7:0] SHORT_ADDR_O,
  output logic [1:0] POINTER_SEL_O,
  output logic SHORT_ADDR_OK_O,
  output logic MOVE_ADDR_OK_O,
  output logic [cie_pkg::ADDR_W-1:0] SRC_EFF_ADDR_O,
  output logic [cie_pkg::ADDR_W-1:0] DST_EFF_ADDR_O,
  output logic [20:0] TABLE_ACCESS_ADDR_O,
  output logic [20:0] TABLE_POINTER_NXT_O,
  output logic SHADOW_SAVE_O,
  output logic SHADOW_RESTORE_O,
  output logic [PC_W-1:0] BRANCH_TARGET_O,
  output logic [19:0] LITERAL_O
);
  import cie_pkg::*;

  typedef enum logic [2:0] {
    CIE_OP_NONE,
    CIE_OP_LIT,
    CIE_OP_STORE,
    CIE_OP_ADD,
    CIE_OP_BSET,
    CIE_OP_ONES
  } cie_op_t;

  cie_phase_t phase_r, phase_nxt;
  cie_op_t op_r, op_nxt;
  logic [INSN_W-1:0] insn_r, insn_nxt;
  logic [DATA_W-1:0] working_accumulator_r, working_accumulator_nxt;
  logic [4:0] flags_r, flags_nxt;
  logic [DATA_W-1:0] opnd_r, opnd_nxt;
  logic [DATA_W-1:0] result_r, result_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic illegal_r, illegal_nxt;

  logic [7:0] opc;
  logic [7:0] kfield;
  logic [2:0] bit_idx;
  cie_op_t op_dec;
  logic [DATA_W:0] sum9;
  logic [4:0] nib_sum;
  logic [DATA_W-1:0] bit_mask;
  logic indexed_store;

  assign opc = INSN_I[15:8];
  assign kfield = insn_r[7:0];
  assign bit_idx = insn_r[BIT_IDX_LSB+2:BIT_IDX_LSB];
  assign bit_mask = 8'h01 << bit_idx;
  assign indexed_store = !insn_r[ACCESS_BIT] && EXT_SET_EN_I
    && (kfield <= IDX_OFFSET_MAX);

  // class decoded from the word on the bus in Q1 and registered with it
  // all-ones tested before store: both share the upper nibble 0110
  always_comb
  begin
    op_dec = CIE_OP_NONE;
    if (opc == OP_LIT_LOAD)
      op_dec = CIE_OP_LIT;
    else if (opc == OP_IDX_ONES)
      op_dec = CIE_OP_ONES;
    else if ((opc & OP_ACC_STORE_MASK) == OP_ACC_STORE)
      op_dec = CIE_OP_STORE;
    else if ((opc & OP_IDX_ADD_MASK) == OP_IDX_ADD)
      op_dec = CIE_OP_ADD;
    else if ((opc & OP_IDX_BSET_MASK) == OP_IDX_BSET)
      op_dec = CIE_OP_BSET;
  end

  assign sum9 = {1'b0, working_accumulator_r} + {1'b0, opnd_r};
  assign nib_sum = {1'b0, working_accumulator_r[3:0]} + {1'b0, opnd_r[3:0]};

  always_comb
  begin
    phase_nxt = phase_r;
    op_nxt = op_r;
    insn_nxt = insn_r;
    working_accumulator_nxt = working_accumulator_r;
    flags_nxt = flags_r;
    opnd_nxt = opnd_r;
    result_nxt = result_r;
    addr_nxt = addr_r;
    illegal_nxt = illegal_r;
    unique case (phase_r)
      CIE_Q1_DECODE:
      begin
        insn_nxt = INSN_I;
        op_nxt = op_dec;
        illegal_nxt = (op_dec == CIE_OP_NONE);
        phase_nxt = CIE_Q2_READ;
      end
      CIE_Q2_READ:
      begin
        unique case (op_r)
          CIE_OP_ADD, CIE_OP_BSET, CIE_OP_ONES:
            addr_nxt = SECOND_INDEX_POINTER_I + {4'h0, kfield};
          CIE_OP_STORE:
            if (indexed_store)
              addr_nxt = SECOND_INDEX_POINTER_I + {4'h0, kfield};
            else if (insn_r[ACCESS_BIT])
              addr_nxt = {BANK_SELECT_REG_I, kfield};
            else if (kfield < ACCESS_SPLIT)
              addr_nxt = {4'h0, kfield};
            else
              addr_nxt = {ACCESS_HIGH_BANK, kfield};
          default:
            addr_nxt = addr_r;
        endcase
        phase_nxt = CIE_Q3_PROCESS;
      end
      CIE_Q3_PROCESS:
      begin
        opnd_nxt = RAM_RDATA_I;
        unique case (op_r)
          CIE_OP_LIT: result_nxt = kfield;
          CIE_OP_STORE: result_nxt = working_accumulator_r;
          CIE_OP_BSET: result_nxt = RAM_RDATA_I | bit_mask;
          CIE_OP_ONES: result_nxt = ALL_ONES;
          default: result_nxt = result_r;
        endcase
        phase_nxt = CIE_Q4_WRITE;
      end
      CIE_Q4_WRITE:
      begin
        if (op_r == CIE_OP_LIT)
          working_accumulator_nxt = result_r;
        // flags come from the operand held since Q3, not from the bus
        if (op_r == CIE_OP_ADD)
        begin
          if (!insn_r[DEST_BIT])
            working_accumulator_nxt = sum9[7:0];
          flags_nxt[FLAG_C] = sum9[8];
          flags_nxt[FLAG_DC] = nib_sum[4];
          flags_nxt[FLAG_Z] = (sum9[7:0] == 8'h00);
          flags_nxt[FLAG_OV] = (working_accumulator_r[7] == opnd_r[7]) && (sum9[7] != working_accumulator_r[7]);
          flags_nxt[FLAG_N] = sum9[7];
        end
        phase_nxt = CIE_Q1_DECODE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      phase_r <= CIE_Q1_DECODE;
      op_r <= CIE_OP_NONE;
      insn_r <= 16'h0000;
      working_accumulator_r <= WORKING_ACCUMULATOR_RESET;
      flags_r <= FLAGS_RESET;
      opnd_r <= 8'h00;
      result_r <= 8'h00;
      addr_r <= 12'h000;
      illegal_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      op_r <= op_nxt;
      insn_r <= insn_nxt;
      working_accumulator_r <= working_accumulator_nxt;
      flags_r <= flags_nxt;
      opnd_r <= opnd_nxt;
      result_r <= result_nxt;
      addr_r <= addr_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // memory strobes; add result written straight from the adder in Q4
  always_comb
  begin
    RAM_RD_O = (phase_r == CIE_Q3_PROCESS)
      && (op_r == CIE_OP_ADD || op_r == CIE_OP_BSET);
    RAM_WR_O = 1'b0;
    RAM_WDATA_O = result_r;
    if (phase_r == CIE_Q4_WRITE)
    begin
      unique case (op_r)
        CIE_OP_STORE, CIE_OP_BSET, CIE_OP_ONES:
          RAM_WR_O = 1'b1;
        CIE_OP_ADD:
        begin
          RAM_WR_O = insn_r[DEST_BIT];
          RAM_WDATA_O = sum9[7:0];
        end
        default:
          RAM_WR_O = 1'b0;
      endcase
    end
  end

  assign INSN_TAKE_O = (phase_r == CIE_Q1_DECODE);
  assign PHASE_O = phase_r;
  assign RAM_ADDR_O = addr_r;
  assign WORKING_ACCUMULATOR_O = working_accumulator_r;
  assign STATUS_FLAGS_O = flags_r;
  assign ILLEGAL_O = illegal_r;

  // field decoders for formats executed elsewhere in the core
  assign SHORT_ADDR_O = INSN_I[7:0];
  assign POINTER_SEL_O = INSN_I[1:0];
  assign SHORT_ADDR_OK_O = (INSN_I[7:0] <= SHORT_ADDR_MAX);
  assign MOVE_ADDR_OK_O = (MOVE_SRC_I <= SRC_ADDR_MAX)
    && (MOVE_DST_I <= DST_ADDR_MAX);
  assign SRC_EFF_ADDR_O = SRC_POINTER_I + {5'h00, INSN_I[13:7]};
  assign DST_EFF_ADDR_O = DST_POINTER_I + {5'h00, INSN_I[6:0]};

  always_comb
  begin
    TABLE_ACCESS_ADDR_O = TABLE_POINTER_I;
    TABLE_POINTER_NXT_O = TABLE_POINTER_I;
    unique case (cie_tbl_mode_t'(POINTER_UPDATE_MODE_I))
      CIE_TBL_NONE: TABLE_POINTER_NXT_O = TABLE_POINTER_I;
      CIE_TBL_POST_INC: TABLE_POINTER_NXT_O = TABLE_POINTER_I + 21'h1;
      CIE_TBL_POST_DEC: TABLE_POINTER_NXT_O = TABLE_POINTER_I - 21'h1;
      CIE_TBL_PRE_INC:
      begin
        TABLE_POINTER_NXT_O = TABLE_POINTER_I + 21'h1;
        TABLE_ACCESS_ADDR_O = TABLE_POINTER_I + 21'h1;
      end
    endcase
  end

  assign SHADOW_SAVE_O = FAST_SELECT_I && IS_CALL_I;
  assign SHADOW_RESTORE_O = FAST_SELECT_I && IS_RETURN_I;

  // relative offset sign-extended; direct form taken as word address
  always_comb
  begin
    if (LIT_WIDTH_SEL_I == 2'h3)
      BRANCH_TARGET_O = PC_W'(INSN_I[7:0]) << 1;
    else
      BRANCH_TARGET_O = PC_I + PC_W'({{(PC_W-11){BRANCH_OFFSET_I[10]}},
        BRANCH_OFFSET_I});
  end

  always_comb
  begin
    unique case (LIT_WIDTH_SEL_I)
      2'h1: LITERAL_O = {8'h00, INSN_I[11:0]};
      2'h2: LITERAL_O = {INSN_I[11:0], INSN_I[7:0]};
      default: LITERAL_O = {12'h000, INSN_I[7:0]};
    endcase
  end
endmodule // cie_core

// ---- sim/cie_ram_model.sv ----
// Purpose: data RAM partner for the decode and execute block
// Assumes: reads are combinational, writes land on the clock edge
// Notes: bytes start from a fixed pattern so reads are known
`timescale 1ns/1ps
module cie_ram_model
(
  input wire logic clk_i,
  input wire logic [11:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [4096];
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
  // unread bus shows inverted data so a stale byte never passes
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
  always @(posedge clk_i) if (wr_i) mem[addr_i] <= wdata_i;
endmodule // cie_ram_model

// ---- sim/cie_core_checker.sv ----
// Purpose: port-level assertions for the decode and execute block
// Assumes: pointer and bank held for a whole instruction
// Notes: edges counted from the capture edge of a word
`timescale 1ns/1ps
module cie_core_checker
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [15:0] INSN_I,
  input wire logic [3:0] BANK_SELECT_REG_I,
  input wire logic [11:0] SECOND_INDEX_POINTER_I,
  input wire logic [7:0] RAM_RDATA_I,
  input wire logic INSN_TAKE_O,
  input wire logic [1:0] PHASE_O,
  input wire logic [11:0] RAM_ADDR_O,
  input wire logic RAM_WR_O,
  input wire logic [7:0] RAM_WDATA_O,
  input wire logic [7:0] WORKING_ACCUMULATOR_O,
  input wire logic [4:0] STATUS_FLAGS_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  wire q1 = PHASE_O == 2'h0;
  wire [7:0] op = INSN_I[15:8];
  wire bset = q1 && INSN_I[15:12] == 4'h8 && !INSN_I[8];
  AST_PHASE_STEP: assert property (1'b1 |=> PHASE_O == $past(PHASE_O) + 2'h1)
    else $error("phase out of order");
  AST_TAKE_Q1: assert property (INSN_TAKE_O == q1)
    else $error("take outside first phase");
  AST_WR_Q4: assert property (RAM_WR_O |-> PHASE_O == 2'h3)
    else $error("write outside last phase");
  AST_ACC_AT_END: assert property ($changed(WORKING_ACCUMULATOR_O) |->
    $past(PHASE_O) == 2'h3) else $error("accumulator moved mid cycle");
  AST_LIT_LOAD: assert property (q1 && op == 8'h0E |-> ##4
    WORKING_ACCUMULATOR_O == $past(INSN_I[7:0], 4)) else $error("literal not loaded");
  AST_FLAGS_KEEP: assert property (q1 && (op == 8'h0E || op[7:1] == 7'h37 || op == 8'h68
    || bset) |-> ##4 STATUS_FLAGS_O == $past(STATUS_FLAGS_O, 4)) else $error("flags moved");
  AST_STORE_BANK: assert property (q1 && op == 8'h6F |-> ##3 RAM_WR_O && RAM_WDATA_O ==
    WORKING_ACCUMULATOR_O && RAM_ADDR_O == {$past(BANK_SELECT_REG_I, 2), $past(INSN_I[7:0], 3)})
    else $error("banked store wrong");
  AST_ALL_ONES: assert property (q1 && op == 8'h68 |-> ##3 RAM_WR_O
    && RAM_WDATA_O == 8'hFF
    && RAM_ADDR_O == $past(SECOND_INDEX_POINTER_I, 2) + $past(INSN_I[7:0], 3))
    else $error("all ones write wrong");
  AST_BIT_SET: assert property (bset |-> ##3 RAM_WR_O && RAM_WDATA_O ==
    ($past(RAM_RDATA_I) | 8'h01 << $past(INSN_I[11:9], 3))) else $error("bit set wrong");
  AST_ADD_DEST: assert property (q1 && op[7:2] == 6'h09 && !op[0] |-> ##3
    RAM_WR_O == $past(INSN_I[9], 3)) else $error("add destination wrong");
  cover property (q1 && op == 8'h0E);
  cover property (bset);
  cover property (q1 && op[7:1] == 7'h37 ##3 RAM_WR_O);
endmodule // cie_core_checker

bind cie_core cie_core_checker cie_core_checker_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .INSN_I(INSN_I), .BANK_SELECT_REG_I(BANK_SELECT_REG_I), .RAM_RDATA_I(RAM_RDATA_I),
  .SECOND_INDEX_POINTER_I(SECOND_INDEX_POINTER_I), .INSN_TAKE_O(INSN_TAKE_O),
  .PHASE_O(PHASE_O), .RAM_ADDR_O(RAM_ADDR_O), .RAM_WR_O(RAM_WR_O), .RAM_WDATA_O(RAM_WDATA_O),
  .WORKING_ACCUMULATOR_O(WORKING_ACCUMULATOR_O), .STATUS_FLAGS_O(STATUS_FLAGS_O));

// ---- sim/tb_cie_core.sv ----
// Purpose: self-checking bench for the decode and execute block
// Assumes: one word offered per four-phase cycle
// Notes: expectations queued at issue; field decodes compared at the capture edge, the rest at completion edges
`timescale 1ns/1ps
module tb_cie_core;
  import cie_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] insn = 16'hFFFF;
  logic ext = 1'b0;
  logic [3:0] bank = 4'h0;
  logic [11:0] ptr = 12'h000;
  logic [20:0] rnd = 21'h0;
  logic [7:0] rdata, wdata, acc;
  logic [11:0] addr;
  logic take, rd, wr;
  logic [1:0] phase;
  logic [1:0] lastph = 2'h0;
  logic [4:0] fl;
  logic [7:0] acc_m = 8'h00;
  logic [4:0] fl_m = 5'h00;
  logic armed = 1'b0;
  logic live = 1'b0;
  logic [19:0] e;
  logic [19:0] wq[$];
  logic [13:0] aq[$];
  logic ill, sok, mok, ss, sr;
  logic [7:0] sa;
  logic [1:0] ps;
  logic [11:0] se, de;
  logic [20:0] ta, tn, bt;
  logic [19:0] lit;
  logic [120:0] f, g;
  logic [120:0] fq[$];
  int checks = 0;
  int num_errors = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  cie_core cie_core_i (.REF_CLK_I(clk), .RST_I(rst), .INSN_I(insn), .EXT_SET_EN_I(ext),
    .BANK_SELECT_REG_I(bank), .SECOND_INDEX_POINTER_I(ptr), .RAM_RDATA_I(rdata), .PC_I(rnd),
    .MOVE_SRC_I(rnd[11:0]), .MOVE_DST_I(rnd[20:9]), .SRC_POINTER_I(rnd[12:1]),
    .DST_POINTER_I(rnd[19:8]), .TABLE_POINTER_I(rnd), .POINTER_UPDATE_MODE_I(rnd[1:0]),
    .FAST_SELECT_I(rnd[2]), .IS_CALL_I(rnd[3]), .IS_RETURN_I(rnd[4]),
    .BRANCH_OFFSET_I(rnd[10:0]), .LIT_WIDTH_SEL_I(rnd[6:5]), .INSN_TAKE_O(take),
    .PHASE_O(phase), .RAM_ADDR_O(addr), .RAM_RD_O(rd), .RAM_WR_O(wr), .RAM_WDATA_O(wdata),
    .WORKING_ACCUMULATOR_O(acc), .STATUS_FLAGS_O(fl), .ILLEGAL_O(ill), .SHORT_ADDR_O(sa),
    .POINTER_SEL_O(ps), .SHORT_ADDR_OK_O(sok), .MOVE_ADDR_OK_O(mok), .SRC_EFF_ADDR_O(se),
    .DST_EFF_ADDR_O(de), .TABLE_ACCESS_ADDR_O(ta), .TABLE_POINTER_NXT_O(tn), .SHADOW_SAVE_O(ss),
    .SHADOW_RESTORE_O(sr), .BRANCH_TARGET_O(bt), .LITERAL_O(lit));
  cie_ram_model cie_ram_model_i (.clk_i(clk), .addr_i(addr), .rd_i(rd), .wr_i(wr),
    .wdata_i(wdata), .rdata_o(rdata));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic issue(input logic [15:0] w);
    logic [11:0] ea;
    logic [8:0] s;
    logic [7:0] m;
    logic [20:0] tp1;
    logic bad;
    @(negedge clk);
    while (take !== 1'b1) @(negedge clk);
    insn = w;
    rnd = 21'($urandom);
    ptr = 12'($urandom);
    bank = 4'($urandom);
    ext = 1'($urandom);
    armed = 1'b1;
    bad = 1'b0;
    tp1 = rnd + 21'h1;
    ea = ptr + 12'(w[7:0]);
    m = cie_ram_model_i.mem[ea];
    s = 9'(acc_m) + 9'(m);
    if (w[15:8] == OP_LIT_LOAD) acc_m = w[7:0];
    else if (w[15:8] == OP_IDX_ONES) wq.push_back({ea, ALL_ONES});
    else if ((w[15:8] & OP_ACC_STORE_MASK) == OP_ACC_STORE)
    begin
      if (w[8]) ea = {bank, w[7:0]};
      else if (!ext || w[7:0] > IDX_OFFSET_MAX)
        ea = {(w[7:0] >= ACCESS_SPLIT) ? ACCESS_HIGH_BANK : 4'h0, w[7:0]};
      wq.push_back({ea, acc_m});
    end
    else if ((w[15:8] & OP_IDX_ADD_MASK) == OP_IDX_ADD)
    begin
      fl_m = {s[7], (acc_m[7] == m[7]) && (s[7] != m[7]), s[7:0] == 8'h00,
        (5'(acc_m[3:0]) + 5'(m[3:0])) > 5'h0F, s[8]};
      if (w[DEST_BIT]) wq.push_back({ea, s[7:0]});
      else acc_m = s[7:0];
    end
    else if ((w[15:8] & OP_IDX_BSET_MASK) == OP_IDX_BSET)
      wq.push_back({ea, m | (8'h01 << w[11:9])});
    else bad = 1'b1;
    aq.push_back({acc_m, fl_m, bad});
    // field decoders: expected from the operand formats, in output order
    fq.push_back({w[7:0], w[1:0], w[7:0] <= SHORT_ADDR_MAX,
      rnd[11:0] <= SRC_ADDR_MAX && rnd[20:9] <= DST_ADDR_MAX,
      12'(rnd[12:1] + 12'(w[13:7])), 12'(rnd[19:8] + 12'(w[6:0])),
      (rnd[1:0] == 2'h3) ? tp1 : rnd,
      (rnd[1:0] == 2'h0) ? rnd : (rnd[1:0] == 2'h2) ? rnd - 21'h1 : tp1,
      rnd[2] & rnd[3], rnd[2] & rnd[4],
      (rnd[6:5] == 2'h3) ? {12'h000, w[7:0], 1'b0} : rnd + {{10{rnd[10]}}, rnd[10:0]},
      (rnd[6:5] == 2'h1) ? {8'h00, w[11:0]}
        : (rnd[6:5] == 2'h2) ? {w[11:0], w[7:0]} : {12'h000, w[7:0]}});
  endtask

  // repeats of a held word are not armed, so only issued words are compared
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      final_report();
    end
    if (!rst && wr === 1'b1)
    begin
      e = (wq.size() > 0) ? wq.pop_front() : 'x;
      check(128'({addr, wdata}), 128'(e), "ram write");
    end
    if (!rst && phase == 2'h0 && lastph == 2'h3 && live)
      check(128'({acc, fl, ill}), 128'(aq.pop_front()), "acc flags");
    if (take === 1'b1)
    begin
      if (armed)
      begin
        f = (fq.size() > 0) ? fq.pop_front() : 'x;
        g = {sa, ps, sok, mok, se, de, ta, tn, ss, sr, bt, lit};
        check(128'(g), 128'(f), "field decode");
      end
      live = armed;
      armed = 1'b0;
    end
    lastph = phase;
  end

  initial
  begin
    void'($urandom(32'hBCB8));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 48; k++)
    begin
      case (k % 6)
        0: issue({OP_LIT_LOAD, 8'($urandom)});
        1: issue({OP_ACC_STORE[7:1], 9'($urandom)});
        2: issue({OP_IDX_ADD[7:2], 1'($urandom), 1'b0, 8'($urandom_range(95))});
        3: issue({OP_IDX_BSET[7:4], 3'(k / 6), 1'b0, 8'($urandom_range(95))});
        4: issue({OP_IDX_ONES, 8'($urandom_range(95))});
        default: issue(16'hFFFF);
      endcase
    end
    issue({OP_IDX_ONES, IDX_OFFSET_MAX});
    issue(16'hFFFF);
    repeat (8) @(negedge clk);
    check(128'(wq.size() + aq.size() + fq.size()), 128'h0, "left over");
    final_report();
  end
endmodule // tb_cie_core
